// ==== src/ptt_pkg.sv ====
// constants for the periodic tick timer: register map, fields, resets
package ptt_pkg;
  localparam int unsigned  PTT_CNT_W        = 24;
  localparam logic [4:0]   PTT_OFF_CTRL     = 5'h00;
  localparam logic [4:0]   PTT_OFF_RELOAD   = 5'h04;
  localparam logic [4:0]   PTT_OFF_CURRENT  = 5'h08;
  localparam logic [4:0]   PTT_OFF_STATUS   = 5'h0c;
  localparam logic [4:0]   PTT_OFF_MASK     = 5'h10;
  localparam int unsigned  PTT_BIT_EN       = 0;
  localparam int unsigned  PTT_BIT_TICKINT  = 1;
  localparam int unsigned  PTT_BIT_TICK     = 0;
  localparam logic [1:0]   PTT_CTRL_RST     = 2'h0;
  localparam logic [23:0]  PTT_RELOAD_RST   = 24'h000000;
  localparam logic         PTT_MASK_RST     = 1'h0;
  localparam logic [1:0]   PTT_RESP_OKAY    = 2'h0;
  localparam logic [1:0]   PTT_RESP_SLVERR  = 2'h2;
endpackage

// ==== src/ptt_timer.sv ====
// periodic tick timer with AXI4-Lite register slave
`timescale 1ns/1ps
// How it works
// - enable low halts the counter, keeps its value, and stops ticks
// - enable high resumes from the held value without any reload
// - any write to current value clears it; next clock with enable high reloads
// - each rollover raises the tick request when tick interrupt enabled
// - with tick interrupt disabled rollovers are silent; counter runs on
// - pending tick clears itself when the core enters the handler
// - rollovers reach the core only while tick interrupt enable is set
// - the current value lies between zero and period minus one, except after a period write drops below it
// - clocks between successive ticks equal the programmed period
module ptt_timer #(
  parameter int unsigned CNT_W  = ptt_pkg::PTT_CNT_W,
  parameter int unsigned ADDR_W = 5
) (
  // clock, reset, enable
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              clk_en,
  // axi4-lite write address and data
  input  wire logic              s_awvalid,
  output logic                   s_awready,
  input  wire logic [ADDR_W-1:0] s_awaddr,
  input  wire logic [2:0]        s_awprot,
  input  wire logic              s_wvalid,
  output logic                   s_wready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  // axi4-lite write response
  output logic                   s_bvalid,
  input  wire logic              s_bready,
  output logic [1:0]             s_bresp,
  // axi4-lite read
  input  wire logic              s_arvalid,
  output logic                   s_arready,
  input  wire logic [ADDR_W-1:0] s_araddr,
  input  wire logic [2:0]        s_arprot,
  output logic                   s_rvalid,
  input  wire logic              s_rready,
  output logic [31:0]            s_rdata,
  output logic [1:0]             s_rresp,
  // interrupt to the core
  input  wire logic              int_ack,
  output logic                   tick_irq
);
  import ptt_pkg::*;

  // refused at elaboration: the read mux and counter hold at most one word
  if (CNT_W < 1 || CNT_W > 32 || ADDR_W < 5 || ADDR_W > 32) begin : g_bad
    $error("ptt_timer: unsupported CNT_W or ADDR_W");
  end

  logic              awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0]        bresp_ff, rresp_ff;
  logic [31:0]       rdata_ff, wdata_ff;
  logic [3:0]        wstrb_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic              en_ff, tickint_ff, status_ff, mask_ff, irq_ff, skip_ff;
  logic [CNT_W-1:0]  reload_ff, cnt_ff, nxt_cnt;
  logic              wr_fire, wr_ok, cur_wr, reload_wr, rollover;
  logic [31:0]       wmask, rd_val;
  logic              rd_ok;

  assign s_awready = awready_ff;
  assign s_wready  = wready_ff;
  assign s_bvalid  = bvalid_ff;
  assign s_bresp   = bresp_ff;
  assign s_arready = arready_ff;
  assign s_rvalid  = rvalid_ff;
  assign s_rdata   = rdata_ff;
  assign s_rresp   = rresp_ff;
  assign tick_irq  = irq_ff;

  // address and data are taken in either order; write happens when both held
  assign wr_fire = !awready_ff && !wready_ff && !bvalid_ff;
  assign wmask   = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                    {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  always_comb begin
    wr_ok = 1'b1;
    unique case (awaddr_ff[4:0])
      PTT_OFF_CTRL, PTT_OFF_RELOAD, PTT_OFF_CURRENT,
      PTT_OFF_STATUS, PTT_OFF_MASK: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
    if (awaddr_ff[ADDR_W-1:0] > ADDR_W'(PTT_OFF_MASK))
      wr_ok = 1'b0;
  end
  assign cur_wr    = wr_fire && wr_ok && awaddr_ff[4:0] == PTT_OFF_CURRENT;
  assign reload_wr = wr_fire && wr_ok && awaddr_ff[4:0] == PTT_OFF_RELOAD;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= PTT_RESP_OKAY;
      awaddr_ff  <= '0;
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
    end else if (clk_en) begin
      if (s_awvalid && awready_ff) begin
        awaddr_ff  <= s_awaddr;
        awready_ff <= 1'b0;
      end
      if (s_wvalid && wready_ff) begin
        wdata_ff  <= s_wdata;
        wstrb_ff  <= s_wstrb;
        wready_ff <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_ok ? PTT_RESP_OKAY : PTT_RESP_SLVERR;
      end
      if (bvalid_ff && s_bready) begin
        bvalid_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  // read path: one outstanding read, data registered
  always_comb begin
    rd_val = 32'h00000000;
    rd_ok  = 1'b1;
    unique case (s_araddr[4:0])
      PTT_OFF_CTRL: begin
        rd_val[PTT_BIT_EN]      = en_ff;
        rd_val[PTT_BIT_TICKINT] = tickint_ff;
      end
      PTT_OFF_RELOAD:  rd_val[CNT_W-1:0] = reload_ff;
      PTT_OFF_CURRENT: rd_val[CNT_W-1:0] = cnt_ff;
      PTT_OFF_STATUS:  rd_val[PTT_BIT_TICK] = status_ff;
      PTT_OFF_MASK:    rd_val[PTT_BIT_TICK] = mask_ff;
      default:         rd_ok = 1'b0;
    endcase
    if (s_araddr[ADDR_W-1:0] > ADDR_W'(PTT_OFF_MASK))
      rd_ok = 1'b0;
    if (!rd_ok)
      rd_val = 32'h00000000;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= PTT_RESP_OKAY;
    end else if (clk_en) begin
      if (s_arvalid && arready_ff) begin
        arready_ff <= 1'b0;
        rvalid_ff  <= 1'b1;
        rdata_ff   <= rd_val;
        rresp_ff   <= rd_ok ? PTT_RESP_OKAY : PTT_RESP_SLVERR;
      end
      if (rvalid_ff && s_rready) begin
        rvalid_ff  <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  // control, reload and mask registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {tickint_ff, en_ff} <= PTT_CTRL_RST;
      reload_ff           <= CNT_W'(PTT_RELOAD_RST);
      mask_ff             <= PTT_MASK_RST;
    end else if (clk_en && wr_fire && wr_ok && wstrb_ff[0]) begin
      if (awaddr_ff[4:0] == PTT_OFF_CTRL) begin
        en_ff      <= wdata_ff[PTT_BIT_EN];
        tickint_ff <= wdata_ff[PTT_BIT_TICKINT];
      end
      if (awaddr_ff[4:0] == PTT_OFF_MASK)
        mask_ff <= wdata_ff[PTT_BIT_TICK];
    end
    if (aresetn && clk_en && reload_wr)
      reload_ff <= CNT_W'((32'(reload_ff) & ~wmask) | (wdata_ff & wmask));
  end

  // counter; a rollover is a reload from zero not caused by a clear
  assign rollover = en_ff && cnt_ff == '0 && !skip_ff && !cur_wr;
  always_comb begin
    nxt_cnt = cnt_ff;
    if (cur_wr)
      nxt_cnt = '0;
    else if (en_ff && cnt_ff == '0)
      nxt_cnt = reload_ff;
    else if (en_ff)
      nxt_cnt = cnt_ff - 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff  <= '0;
      skip_ff <= 1'b0;
    end else if (clk_en) begin
      cnt_ff <= nxt_cnt;
      // the reload after a clear is not a period end, so it raises no tick
      if (cur_wr)
        skip_ff <= 1'b1;
      else if (en_ff && cnt_ff == '0)
        skip_ff <= 1'b0;
    end
  end

  // sticky tick flag; a new rollover wins over acknowledge or clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= 1'b0;
      irq_ff    <= 1'b0;
    end else if (clk_en) begin
      if (rollover && tickint_ff)
        status_ff <= 1'b1;
      else if (int_ack)
        status_ff <= 1'b0;
      else if (wr_fire && wr_ok && wstrb_ff[0] &&
               awaddr_ff[4:0] == PTT_OFF_STATUS && wdata_ff[PTT_BIT_TICK])
        status_ff <= 1'b0;
      irq_ff <= status_ff && mask_ff && tickint_ff;
    end
  end

  // helper: clocks since last rollover, spoiled by any disturbance
  logic [CNT_W:0] gap_ff;
  logic           gap_ok_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_ff    <= '0;
      gap_ok_ff <= 1'b0;
    end else if (clk_en) begin
      gap_ff    <= rollover ? (CNT_W+1)'(1) : gap_ff + 1'b1;
      // a period written at the rollover itself applies one period late
      gap_ok_ff <= rollover ? !reload_wr :
                   gap_ok_ff && en_ff && !cur_wr && !reload_wr;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_cleared;
    cnt_ff == '0 && clk_en && en_ff && !cur_wr;
  endsequence

  a_hold_when_off: assert property (
    clk_en && !en_ff && !cur_wr
      |=> $stable(cnt_ff) && !$rose(status_ff))
    else $error("counter moved while disabled");
  a_resume_no_reload: assert property (
    clk_en && $rose(en_ff) && cnt_ff != '0 && !cur_wr
      |=> cnt_ff == $past(cnt_ff) - 1'b1)
    else $error("enable reloaded instead of resuming");
  a_clear_zero: assert property (
    clk_en && cur_wr |=> cnt_ff == '0)
    else $error("current write did not clear counter");
  a_clear_then_load: assert property (
    clk_en && cur_wr ##1 s_cleared |=> cnt_ff == $past(reload_ff))
    else $error("cleared counter did not reload");
  a_clear_silent: assert property (
    clk_en && cur_wr ##1 s_cleared |-> !rollover)
    else $error("reload after clear raised a tick");
  a_tick_on_roll: assert property (
    clk_en && rollover && tickint_ff |=> status_ff)
    else $error("rollover did not raise tick");
  a_irq_follows: assert property (
    clk_en && status_ff && mask_ff && tickint_ff |=> tick_irq)
    else $error("pending tick did not reach the core");
  a_silent_when_off: assert property (
    clk_en && !tickint_ff && !status_ff |=> !status_ff)
    else $error("tick flagged with tick interrupt disabled");
  a_ack_clears: assert property (
    clk_en && int_ack && !(rollover && tickint_ff) |=> !status_ff)
    else $error("handler entry left tick pending");
  a_irq_gate: assert property (
    tick_irq |-> $past(status_ff) && $past(tickint_ff) && $past(mask_ff))
    else $error("tick reached core while gated");
  a_value_range: assert property (
    clk_en && cnt_ff <= reload_ff && !reload_wr |=> cnt_ff <= reload_ff)
    else $error("current value beyond period minus one");
  a_tick_spacing: assert property (
    rollover && gap_ok_ff |-> gap_ff == {1'b0, reload_ff} + 1'b1)
    else $error("tick spacing differs from period");
  a_count_down: assert property (
    clk_en && en_ff && !cur_wr |=> cnt_ff == ($past(cnt_ff) == '0 ?
      $past(reload_ff) : $past(cnt_ff) - 1'b1))
    else $error("counter step wrong");

  // handler entry and write one both drop the line
  a_irq_drop: assert property (
    clk_en && !status_ff |=> !tick_irq)
    else $error("tick line stayed up with nothing pending");
  a_status_w1c: assert property (
    clk_en && wr_fire && wr_ok && wstrb_ff[0] && wdata_ff[PTT_BIT_TICK]
      && awaddr_ff[4:0] == PTT_OFF_STATUS && !(rollover && tickint_ff)
      |=> !status_ff)
    else $error("write one did not clear tick");

  // bus: address channels stay refused until the answer is taken
  a_aw_refused: assert property (
    clk_en && !s_awready && !(s_bvalid && s_bready) |=> !s_awready)
    else $error("write address accepted while busy");
  a_ar_refused: assert property (
    clk_en && !s_arready && !(s_rvalid && s_rready) |=> !s_arready)
    else $error("read address accepted while busy");
endmodule

// ==== sim/ptt_core_model.sv ====
// model of the core interrupt controller that enters the tick handler
`timescale 1ns/1ps
module ptt_core_model (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // handler entry control and interrupt pair
  input  wire logic ack_en,
  input  wire logic tick_irq,
  output logic      int_ack
);
  logic busy_ff;
  // one handler entry per request; rearm only once the line has dropped
  always_ff @(posedge aclk) begin
    int_ack <= 1'b0;
    if (!aresetn) begin
      busy_ff <= 1'b0;
    end else if (!busy_ff && ack_en && tick_irq) begin
      int_ack <= 1'b1;
      busy_ff <= 1'b1;
    end else if (!tick_irq) begin
      busy_ff <= 1'b0;
    end
  end
endmodule

// ==== sim/testbench.sv ====
// self-checking bench for the periodic tick timer
`timescale 1ns/1ps
module testbench;
  import ptt_pkg::*;
  localparam int P = 20;
  logic        aclk = 0, aresetn = 0, ack_en = 0, int_ack, tick_irq;
  logic        s_awvalid = 0, s_wvalid = 0, s_bready = 0;
  logic        s_arvalid = 0, s_rready = 0, prev_irq = 0, clk_en = 1;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [4:0]  s_awaddr = 0, s_araddr = 0;
  logic [31:0] s_wdata = 0, s_rdata, rv, h;
  logic [1:0]  s_bresp, s_rresp, rsp;
  logic [4:0]  offs [5] = '{PTT_OFF_CTRL, PTT_OFF_RELOAD, PTT_OFF_CURRENT,
                            PTT_OFF_STATUS, PTT_OFF_MASK};
  int          failures = 0, comparisons = 0, cyc = 0, rises = 0, r = 0;
  int          last = 0, gap = 0;
  ptt_timer i_dut (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_awaddr(s_awaddr),
    .s_awprot(3'h0), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_wdata(s_wdata), .s_wstrb(4'hf), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_bresp(s_bresp), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_araddr(s_araddr), .s_arprot(3'h0),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .int_ack(int_ack), .tick_irq(tick_irq));
  ptt_core_model i_core (.aclk(aclk), .aresetn(aresetn), .ack_en(ack_en),
    .tick_irq(tick_irq), .int_ack(int_ack));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    s_awaddr  <= a;
    s_wdata   <= d;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    rsp = s_bresp;
    s_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rr(input logic [4:0] a);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    rv  = s_rdata;
    rsp = s_rresp;
    s_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic results;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial forever #2.5 aclk = ~aclk;
  // rising edges of the interrupt and the spacing between the last two
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    prev_irq <= tick_irq;
    if (tick_irq === 1'b1 && prev_irq === 1'b0) begin
      rises <= rises + 1;
      gap <= cyc - last;
      last <= cyc;
    end
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (offs[i]) begin
      rr(offs[i]);
      chk(rv, 32'h0);
      chk(32'(rsp), 32'(PTT_RESP_OKAY));
    end
    rr(5'h14);
    chk(32'(rsp), 32'(PTT_RESP_SLVERR));
    wr(5'h14, 32'h1);
    chk(32'(rsp), 32'(PTT_RESP_SLVERR));
    $display("test reset and map done");
    wr(PTT_OFF_RELOAD, P - 1);
    chk(32'(rsp), 32'(PTT_RESP_OKAY));
    wr(PTT_OFF_MASK, 32'h1);
    wr(PTT_OFF_CURRENT, 32'h5a5a5a5a);
    wr(PTT_OFF_CTRL, 32'h3);
    repeat (P + 5) @(posedge aclk);
    wr(PTT_OFF_CTRL, 32'h2);
    rr(PTT_OFF_STATUS);
    chk(rv, 32'h1);
    chk(32'(tick_irq), 32'h1);
    wr(PTT_OFF_MASK, 32'h0);
    chk(32'(tick_irq), 32'h0);
    wr(PTT_OFF_MASK, 32'h1);
    chk(32'(tick_irq), 32'h1);
    wr(PTT_OFF_STATUS, 32'h1);
    chk(32'(tick_irq), 32'h0);
    $display("test pending, mask and clear done");
    ack_en <= 1'b1;
    r = rises;
    wr(PTT_OFF_CTRL, 32'h3);
    repeat (3 * P + 10) @(posedge aclk);
    chk(32'(gap), P);
    chk(32'(rises >= r + 3), 32'h1);
    repeat (6) begin
      rr(PTT_OFF_CURRENT);
      chk(32'(rv < P), 32'h1);
    end
    $display("test period and handler entry done");
    wr(PTT_OFF_CTRL, 32'h2);
    rr(PTT_OFF_CURRENT);
    h = rv;
    r = rises;
    repeat (2 * P) @(posedge aclk);
    rr(PTT_OFF_CURRENT);
    chk(rv, h);
    chk(32'(rises), 32'(r));
    wr(PTT_OFF_CTRL, 32'h3);
    rr(PTT_OFF_CURRENT);
    chk(32'(((h + P - rv) % P) inside {[1:10]}), 32'h1);
    wr(PTT_OFF_CURRENT, 32'hffffffff);
    rr(PTT_OFF_CURRENT);
    chk(32'(rv inside {[P - 8:P - 1]}), 32'h1);
    $display("test halt, resume and clear done");
    wr(PTT_OFF_CTRL, 32'h1);
    r = rises;
    rr(PTT_OFF_CURRENT);
    h = rv;
    repeat (P + 7) @(posedge aclk);
    rr(PTT_OFF_CURRENT);
    chk(32'(rv != h), 32'h1);
    chk(32'(rises), 32'(r));
    rr(PTT_OFF_STATUS);
    chk(rv, 32'h0);
    rr(PTT_OFF_CURRENT);
    h = rv;
    clk_en <= 1'b0;
    repeat (30) @(posedge aclk);
    clk_en <= 1'b1;
    rr(PTT_OFF_CURRENT);
    chk((h + P - rv) % P, 32'h3);
    $display("test silent rollovers and clock enable done");
    results();
  end
endmodule
